// ---- hw/acr_pkg.sv ----
// acr_pkg: constants and carrier types for the configuration/status bank
// assumes a host on a 16-bit parallel bus and fifo occupancy counts
package acr_pkg;
    // control register bit positions
    localparam int CFG_RX1_RATE = 0;
    localparam int CFG_LBL_MEM = 1;
    localparam int CFG_RX1_LBL_EN = 2;
    localparam int CFG_RX2_LBL_EN = 3;
    localparam int CFG_PAR_EN = 4;
    localparam int CFG_LOOP_N = 5;
    localparam int CFG_RX1_DEC_EN = 6;
    localparam int CFG_RX1_REF9 = 7;
    localparam int CFG_RX1_REF10 = 8;
    localparam int CFG_RX2_DEC_EN = 9;
    localparam int CFG_RX2_REF9 = 10;
    localparam int CFG_RX2_REF10 = 11;
    localparam int CFG_PAR_SENSE = 12;
    localparam int CFG_TX_RATE = 13;
    localparam int CFG_RX2_RATE = 14;
    localparam int CFG_BIT_MAP = 15;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // status register layout
    localparam int STAT_WIDTH = 9;
    localparam int STAT_PER_RX = 3;
    localparam int STAT_TX_EMPTY = 6;
    localparam int STAT_TX_FULL = 7;
    localparam int STAT_TX_HALF = 8;
    // fifo geometry
    localparam int FIFO_CNT_W = 6;
    localparam logic [5:0] FIFO_DEPTH = 6'h20;
    localparam logic [5:0] FIFO_HALF = 6'h10;
    // bit clock dividers
    localparam logic [6:0] DIV_FAST = 7'h0a;
    localparam logic [6:0] DIV_SLOW = 7'h50;
    localparam int NUM_RX = 2;

    typedef struct packed {
        logic match_en;
        logic dec_en;
        logic ref9;
        logic ref10;
        logic rate_slow;
    } acr_rx_cfg_t;

    typedef struct packed {
        logic par_en;
        logic par_sense;
        logic rate_slow;
    } acr_tx_cfg_t;
endpackage : acr_pkg

// ---- hw/acr_regs.sv ----
// acr_regs: control and status register bank of the dual-receiver,
// single-transmitter serial interface, with bit-rate enables, word filter,
// transmit parity, loopback steering and host bit mapping.
// assumes host strobes are synchronous to clk_sys; fifo counts come in.
//
// Contract
// - config write strobe low loads all 16 bus bits into control register
// - read strobe low with select high drives control register onto bus
// - per-channel rate bit picks clock/10 when clear, clock/80 when set
// - label memory bit routes load strobes and read enables to label memory
// - drop received words failing enabled label or bit 9/10 checks
// - parity enable puts parity in bit 32, otherwise host data bit
// - parity sense clear gives odd parity, set gives even
// - self test bit clear loops transmitter outputs into receivers
// - receiver one decoder compares bits 9,10 with its reference bits
// - receiver two decoder compares bits 9,10 with its own reference bits
// - format bit chooses between two word-to-half-word bit mappings
// - read strobe low with select low puts nine status bits on bus
// - status read drives bus bits above the nine status bits to zero
// - data-ready bit set while fifo nonempty; pin inverted
// - half-full bit set at sixteen or more words; pin inverted
// - full bit set while fifo full; pin inverted
// - transmit empty bit set when transmit fifo holds no words
// - transmit full bit set while fifo full; pin inverted
// - transmit half-full bit set at sixteen or more words; pin inverted
`timescale 1ns/10ps
module acr_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // host bus
    input wire logic config_write_strobe_n,
    input wire logic register_read_strobe_n,
    input wire logic half_select,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    // host word strobes
    input wire logic tx_load_low_half_n,
    input wire logic tx_load_high_half_n,
    input wire logic rx_one_read_enable_n,
    input wire logic rx_two_read_enable_n,
    // fifo occupancy
    input wire logic [5:0] rx_one_count,
    input wire logic [5:0] rx_two_count,
    input wire logic [5:0] tx_count,
    // status pins, active low
    output logic rx_one_ready_pin,
    output logic rx_two_ready_pin,
    output logic rx_one_half_pin,
    output logic rx_two_half_pin,
    output logic rx_one_full_pin,
    output logic rx_two_full_pin,
    output logic tx_full_pin,
    output logic tx_half_pin,
    // bit-rate enables
    output logic rx_one_bit_en,
    output logic rx_two_bit_en,
    output logic tx_bit_en,
    // received word filter
    input wire logic [31:0] rx_one_word,
    input wire logic [31:0] rx_two_word,
    input wire logic rx_one_label_hit,
    input wire logic rx_two_label_hit,
    output logic rx_one_accept,
    output logic rx_two_accept,
    // transmit word bit 32
    input wire logic [31:0] tx_word,
    output logic tx_bit32,
    // serial loopback
    input wire logic [1:0] serial_line_outputs,
    input wire logic [1:0] rx_one_line_in,
    input wire logic [1:0] rx_two_line_in,
    output logic [1:0] rx_one_logic_in,
    output logic [1:0] rx_two_logic_in,
    // label memory steering
    output logic lbl_mem_write_low,
    output logic lbl_mem_write_high,
    output logic lbl_mem_read_one,
    output logic lbl_mem_read_two,
    output logic tx_fifo_load_low,
    output logic tx_fifo_load_high,
    output logic rx_one_fifo_read,
    output logic rx_two_fifo_read,
    // bit mapping, both directions
    input wire logic [31:0] map_word_in,
    input wire logic [15:0] map_half_low,
    input wire logic [15:0] map_half_high,
    output logic [15:0] map_byte1_out,
    output logic [15:0] map_byte2_out,
    output logic [31:0] map_word_out
);
    logic [15:0] cfg_r, cfg_nxt;
    logic [15:0] dout_r, dout_nxt;
    logic oe_n_r, oe_n_nxt;
    logic [8:0] stat;
    logic [6:0] div_r [3], div_nxt [3];
    logic [2:0] bit_en_r, bit_en_nxt;
    logic [2:0] slow;
    logic [5:0] cnt [3];
    acr_pkg::acr_rx_cfg_t rx_cfg [2];
    acr_pkg::acr_tx_cfg_t tx_cfg;
    logic [1:0] dec_ok, lbl_ok;
    logic [31:0] rx_w [2];

    // control register
    always_comb begin
        cfg_nxt = cfg_r;
        if (!config_write_strobe_n)
            cfg_nxt = host_data_bus_in;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            cfg_r <= acr_pkg::CFG_RESET;
        else
            cfg_r <= cfg_nxt;
    end

    assign rx_cfg[0] = '{cfg_r[acr_pkg::CFG_RX1_LBL_EN],
        cfg_r[acr_pkg::CFG_RX1_DEC_EN], cfg_r[acr_pkg::CFG_RX1_REF9],
        cfg_r[acr_pkg::CFG_RX1_REF10], cfg_r[acr_pkg::CFG_RX1_RATE]};
    assign rx_cfg[1] = '{cfg_r[acr_pkg::CFG_RX2_LBL_EN],
        cfg_r[acr_pkg::CFG_RX2_DEC_EN], cfg_r[acr_pkg::CFG_RX2_REF9],
        cfg_r[acr_pkg::CFG_RX2_REF10], cfg_r[acr_pkg::CFG_RX2_RATE]};
    assign tx_cfg = '{cfg_r[acr_pkg::CFG_PAR_EN],
        cfg_r[acr_pkg::CFG_PAR_SENSE], cfg_r[acr_pkg::CFG_TX_RATE]};

    // status from live fifo counts
    assign cnt[0] = rx_one_count;
    assign cnt[1] = rx_two_count;
    assign cnt[2] = tx_count;
    assign rx_w[0] = rx_one_word;
    assign rx_w[1] = rx_two_word;
    assign slow = {tx_cfg.rate_slow, rx_cfg[1].rate_slow,
        rx_cfg[0].rate_slow};

    genvar g;
    generate
        for (g = 0; g < acr_pkg::NUM_RX; g++) begin : g_rx
            assign stat[g*3] = (cnt[g] != 6'h00);
            assign stat[g*3+1] = (cnt[g] >= acr_pkg::FIFO_HALF);
            assign stat[g*3+2] = (cnt[g] == acr_pkg::FIFO_DEPTH);
            // bit 9 is index 8, bit 10 index 9 of the 32-bit word
            assign dec_ok[g] = !rx_cfg[g].dec_en ||
                ((rx_w[g][8] == rx_cfg[g].ref9) &&
                 (rx_w[g][9] == rx_cfg[g].ref10));
        end
        for (g = 0; g < 3; g++) begin : g_div
            always_comb begin
                div_nxt[g] = div_r[g] + 7'h01;
                bit_en_nxt[g] = 1'b0;
                if (div_r[g] >= (slow[g] ? acr_pkg::DIV_SLOW
                                         : acr_pkg::DIV_FAST) - 7'h01) begin
                    div_nxt[g] = 7'h00;
                    bit_en_nxt[g] = 1'b1;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    div_r[g] <= 7'h00;
                    bit_en_r[g] <= 1'b0;
                end else begin
                    div_r[g] <= div_nxt[g];
                    bit_en_r[g] <= bit_en_nxt[g];
                end
            end
        end
    endgenerate
    assign stat[acr_pkg::STAT_TX_EMPTY] = (tx_count == 6'h00);
    assign stat[acr_pkg::STAT_TX_FULL] =
        (tx_count == acr_pkg::FIFO_DEPTH);
    assign stat[acr_pkg::STAT_TX_HALF] =
        (tx_count >= acr_pkg::FIFO_HALF);

    assign rx_one_bit_en = bit_en_r[0];
    assign rx_two_bit_en = bit_en_r[1];
    assign tx_bit_en = bit_en_r[2];

    // pins are the inverse of their status bits
    assign rx_one_ready_pin = !stat[0];
    assign rx_one_half_pin = !stat[1];
    assign rx_one_full_pin = !stat[2];
    assign rx_two_ready_pin = !stat[3];
    assign rx_two_half_pin = !stat[4];
    assign rx_two_full_pin = !stat[5];
    assign tx_full_pin = !stat[acr_pkg::STAT_TX_FULL];
    assign tx_half_pin = !stat[acr_pkg::STAT_TX_HALF];

    // word filter
    assign lbl_ok[0] = !rx_cfg[0].match_en || rx_one_label_hit;
    assign lbl_ok[1] = !rx_cfg[1].match_en || rx_two_label_hit;
    assign rx_one_accept = lbl_ok[0] && dec_ok[0];
    assign rx_two_accept = lbl_ok[1] && dec_ok[1];

    // transmit bit 32: parity over bits 1..31 or host data
    assign tx_bit32 = tx_cfg.par_en ?
        (^tx_word[30:0]) ^ !tx_cfg.par_sense : tx_word[31];

    // loopback when self-test bit is clear
    assign rx_one_logic_in = cfg_r[acr_pkg::CFG_LOOP_N] ?
        rx_one_line_in : serial_line_outputs;
    assign rx_two_logic_in = cfg_r[acr_pkg::CFG_LOOP_N] ?
        rx_two_line_in : serial_line_outputs;

    // label memory steering
    assign lbl_mem_write_low = cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !tx_load_low_half_n;
    assign lbl_mem_write_high = cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !tx_load_high_half_n;
    assign lbl_mem_read_one = cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !rx_one_read_enable_n;
    assign lbl_mem_read_two = cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !rx_two_read_enable_n && rx_one_read_enable_n;
    assign tx_fifo_load_low = !cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !tx_load_low_half_n;
    assign tx_fifo_load_high = !cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !tx_load_high_half_n;
    assign rx_one_fifo_read = !cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !rx_one_read_enable_n;
    assign rx_two_fifo_read = !cfg_r[acr_pkg::CFG_LBL_MEM] &&
        !rx_two_read_enable_n && rx_one_read_enable_n;

    // bit mapping; format 0 reverses label and swaps fields
    always_comb begin
        if (cfg_r[acr_pkg::CFG_BIT_MAP]) begin
            map_byte1_out = map_word_in[15:0];
            map_byte2_out = map_word_in[31:16];
            map_word_out = {map_half_high, map_half_low};
        end else begin
            map_byte1_out = {map_word_in[12:8], map_word_in[30:29],
                map_word_in[31], map_word_in[0], map_word_in[1],
                map_word_in[2], map_word_in[3], map_word_in[4],
                map_word_in[5], map_word_in[6], map_word_in[7]};
            map_byte2_out = map_word_in[28:13];
            map_word_out = {map_half_low[8], map_half_low[10:9],
                map_half_high, map_half_low[15:11], map_half_low[0],
                map_half_low[1], map_half_low[2], map_half_low[3],
                map_half_low[4], map_half_low[5], map_half_low[6],
                map_half_low[7]};
        end
    end

    // register read port
    always_comb begin
        dout_nxt = dout_r;
        oe_n_nxt = 1'b1;
        if (!register_read_strobe_n) begin
            oe_n_nxt = 1'b0;
            if (half_select)
                dout_nxt = cfg_r;
            else
                dout_nxt = {7'h00, stat};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dout_r <= 16'h0000;
            oe_n_r <= 1'b1;
        end else begin
            dout_r <= dout_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end
    assign host_data_bus_out = dout_r;
    assign host_data_bus_oe_n = oe_n_r;

    cfg_load_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !config_write_strobe_n |=> cfg_r == $past(host_data_bus_in))
        else $error("control register missed write");
    cfg_hold_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        config_write_strobe_n |=> $stable(cfg_r))
        else $error("control register changed without write");
    cfg_read_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !register_read_strobe_n && half_select && config_write_strobe_n
        |=> !host_data_bus_oe_n && host_data_bus_out == cfg_r)
        else $error("control read wrong");
    stat_read_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !register_read_strobe_n && !half_select
        |=> !host_data_bus_oe_n && host_data_bus_out[15:9] == 7'h00
            && host_data_bus_out[8:0] == $past(stat))
        else $error("status read wrong");
    ready_pin_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        rx_one_ready_pin == (rx_one_count == 6'h00))
        else $error("ready pin wrong");
    half_pin_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        rx_two_half_pin == (rx_two_count < acr_pkg::FIFO_HALF))
        else $error("half pin wrong");
    full_pin_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        tx_full_pin == (tx_count != acr_pkg::FIFO_DEPTH))
        else $error("tx full pin wrong");
    // next pulse ten clocks after the last when fast rate is in force
    fast_rate_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        $rose(tx_bit_en) ##9 !cfg_r[acr_pkg::CFG_TX_RATE] |=> tx_bit_en)
        else $error("fast bit rate wrong");
    loop_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !cfg_r[acr_pkg::CFG_LOOP_N]
        |-> rx_one_logic_in == serial_line_outputs)
        else $error("loopback wrong");
    parity_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        cfg_r[acr_pkg::CFG_PAR_EN]
        |-> ^{tx_bit32, tx_word[30:0]} == !cfg_r[acr_pkg::CFG_PAR_SENSE])
        else $error("parity wrong");
endmodule : acr_regs

// ---- verification/acr_host_model.sv ----
// acr_host_model: host processor on the 16-bit register bus
// assumes the device samples both strobes on rising clk_sys edges
`timescale 1ns/10ps
module acr_host_model (
    // clock
    input wire logic clk_sys,
    // strobes and bus
    output logic wr_n,
    output logic rd_n,
    output logic sel,
    output logic [15:0] bus_in,
    input wire logic [15:0] bus_out,
    input wire logic oe_n
);
    logic [15:0] d = 16'h0000;
    logic drv = 1'b0;
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        sel = 1'b0;
    end
    // a released bus shows the inverse of the last value
    assign bus_in = !oe_n ? bus_out : (drv ? d : ~d);
    task automatic wr(input logic [15:0] x);
        @(posedge clk_sys);
        wr_n <= 1'b0;
        drv <= 1'b1;
        d <= x;
        @(posedge clk_sys);
        wr_n <= 1'b1;
        drv <= 1'b0;
    endtask : wr
    task automatic rd(input logic s, output logic [15:0] x, output logic o);
        @(posedge clk_sys);
        rd_n <= 1'b0;
        sel <= s;
        @(posedge clk_sys);
        @(posedge clk_sys);
        x = bus_out;
        o = oe_n;
        rd_n <= 1'b1;
    endtask : rd
endmodule : acr_host_model

// ---- verification/tb_top.sv ----
// tb_top: bench for the configuration and status register bank
// assumes a 250 MHz clk_sys and the host model on the register bus
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic config_write_strobe_n, register_read_strobe_n, half_select;
    logic [15:0] host_data_bus_in, host_data_bus_out;
    logic host_data_bus_oe_n;
    logic tx_load_low_half_n = 1'b1, tx_load_high_half_n = 1'b1;
    logic rx_one_read_enable_n = 1'b1, rx_two_read_enable_n = 1'b1;
    logic [5:0] rx_one_count = 6'h00, rx_two_count = 6'h00, tx_count = 6'h00;
    logic [31:0] rx_one_word = 32'h0, rx_two_word = 32'h0;
    logic [31:0] tx_word = 32'h8000_0007, map_word_in = 32'h1234_5678;
    logic rx_one_label_hit = 1'b0, rx_two_label_hit = 1'b0;
    logic [1:0] serial_line_outputs = 2'h1, rx_one_line_in = 2'h2;
    logic [1:0] rx_two_line_in = 2'h3, rx_one_logic_in, rx_two_logic_in;
    logic [15:0] map_half_low = 16'h0f0f, map_half_high = 16'hf0f0;
    logic rx_one_ready_pin, rx_two_ready_pin, rx_one_half_pin, rx_two_half_pin;
    logic rx_one_full_pin, rx_two_full_pin, tx_full_pin, tx_half_pin;
    logic rx_one_bit_en, rx_two_bit_en, tx_bit_en, tx_bit32;
    logic rx_one_accept, rx_two_accept, lbl_mem_read_one, lbl_mem_read_two;
    logic lbl_mem_write_low, lbl_mem_write_high, tx_fifo_load_low;
    logic tx_fifo_load_high, rx_one_fifo_read, rx_two_fifo_read;
    logic [2:0] ben;
    logic [7:0] pins;
    logic [15:0] map_byte1_out, map_byte2_out;
    logic [31:0] map_word_out;
    logic [15:0] v;
    logic o;
    logic [8:0] s;
    int n;
    int n_errors = 0;
    int checks = 0;
    logic [5:0] ca[4] = '{6'h00, 6'h01, 6'h10, 6'h20};
    logic [5:0] cb[4] = '{6'h00, 6'h0f, 6'h20, 6'h1f};
    logic [5:0] cc[4] = '{6'h00, 6'h10, 6'h1f, 6'h20};
    assign ben = {tx_bit_en, rx_two_bit_en, rx_one_bit_en};
    assign pins = {tx_half_pin, tx_full_pin, rx_two_full_pin, rx_two_half_pin,
        rx_two_ready_pin, rx_one_full_pin, rx_one_half_pin, rx_one_ready_pin};
    always #2 clk_sys = ~clk_sys;
    acr_regs dut_u (
        .clk_sys, .sys_rst, .config_write_strobe_n, .register_read_strobe_n,
        .half_select, .host_data_bus_in, .host_data_bus_out,
        .host_data_bus_oe_n, .tx_load_low_half_n, .tx_load_high_half_n,
        .rx_one_read_enable_n, .rx_two_read_enable_n, .rx_one_count,
        .rx_two_count, .tx_count, .rx_one_ready_pin, .rx_two_ready_pin,
        .rx_one_half_pin, .rx_two_half_pin, .rx_one_full_pin,
        .rx_two_full_pin, .tx_full_pin, .tx_half_pin, .rx_one_bit_en,
        .rx_two_bit_en, .tx_bit_en, .rx_one_word, .rx_two_word,
        .rx_one_label_hit, .rx_two_label_hit, .rx_one_accept, .rx_two_accept,
        .tx_word, .tx_bit32, .serial_line_outputs, .rx_one_line_in,
        .rx_two_line_in, .rx_one_logic_in, .rx_two_logic_in,
        .lbl_mem_write_low, .lbl_mem_write_high, .lbl_mem_read_one,
        .lbl_mem_read_two, .tx_fifo_load_low, .tx_fifo_load_high,
        .rx_one_fifo_read, .rx_two_fifo_read, .map_word_in, .map_half_low,
        .map_half_high, .map_byte1_out, .map_byte2_out, .map_word_out
    );
    acr_host_model host_u (
        .clk_sys, .wr_n(config_write_strobe_n),
        .rd_n(register_read_strobe_n), .sel(half_select),
        .bus_in(host_data_bus_in), .bus_out(host_data_bus_out),
        .oe_n(host_data_bus_oe_n)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    // cycles between two bit-rate pulses of one channel
    task automatic per(input int w, output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            #1;
            c++;
        end while (!ben[w] && c < 200);
        c = 0;
        do begin
            @(posedge clk_sys);
            #1;
            c++;
        end while (!ben[w] && c < 200);
    endtask : per
    function automatic logic [8:0] st(input logic [5:0] a, b, c);
        return {c >= 6'h10, c == 6'h20, c == 6'h00, b == 6'h20, b >= 6'h10,
            b != 6'h00, a == 6'h20, a >= 6'h10, a != 6'h00};
    endfunction : st
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        host_u.rd(1'b1, v, o);
        chk({o, v}, 17'h00000);
        for (int k = 0; k < 2; k++) begin
            host_u.wr(k ? 16'h5a3c : 16'ha5c3);
            host_u.rd(1'b1, v, o);
            chk({o, v}, k ? 17'h05a3c : 17'h0a5c3);
        end
        repeat (2) @(posedge clk_sys);
        #1;
        chk(host_data_bus_oe_n, 1'b1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            rx_one_count <= ca[k];
            rx_two_count <= cb[k];
            tx_count <= cc[k];
            // a full receive count is read back well inside a word period
            host_u.rd(1'b0, v, o);
            s = st(ca[k], cb[k], cc[k]);
            chk({o, v}, {8'h00, s});
            chk(pins ^ 8'hff, {s[8:7], s[5:0]});
        end
        for (int r = 0; r < 2; r++) begin
            host_u.wr(r ? 16'h6001 : 16'h0000);
            for (int w = 0; w < 3; w++) begin
                per(w, n);
                per(w, n);
                chk(n, r ? 80 : 10);
            end
        end
        for (int i = 0; i < 16; i++) begin
            host_u.wr(16'h0c80 | (i[0] ? 16'h000c : 16'h0000)
                | (i[2] ? 16'h0240 : 16'h0000));
            rx_one_label_hit <= i[1];
            rx_two_label_hit <= i[1];
            rx_one_word <= {22'h0, !i[3], 1'b1, 8'h00};
            rx_two_word <= {22'h0, i[3], 1'b1, 8'h00};
            @(posedge clk_sys);
            #1;
            chk({rx_one_accept, rx_two_accept},
                {2{(!i[0] | i[1]) & (!i[2] | i[3])}});
        end
        for (int p = 0; p < 8; p++) begin
            host_u.wr({3'h0, p[1], 6'h0, p[2], p[0], 2'h0, p[2], 1'b0});
            tx_load_low_half_n <= 1'b0;
            tx_load_high_half_n <= p[0];
            rx_one_read_enable_n <= p[0];
            rx_two_read_enable_n <= 1'b0;
            @(posedge clk_sys);
            #1;
            chk(tx_bit32,
                p[0] ? ~^{p[1], tx_word[30:0]} : tx_word[31]);
            chk({rx_one_logic_in, rx_two_logic_in},
                p[2] ? 4'hb : 4'h5);
            chk({lbl_mem_write_low, lbl_mem_write_high,
                tx_fifo_load_low, tx_fifo_load_high, lbl_mem_read_one,
                lbl_mem_read_two, rx_one_fifo_read, rx_two_fifo_read},
                {p[2], p[2] & !p[0], !p[2], !p[2] & !p[0], p[2] & !p[0],
                p[2] & p[0], !p[2] & !p[0], !p[2] & p[0]});
        end
        for (int f = 0; f < 2; f++) begin
            host_u.wr(f ? 16'h8000 : 16'h0000);
            @(posedge clk_sys);
            #1;
            chk({map_byte1_out, map_byte2_out},
                f ? 32'h5678_1234 : 32'hb01e_91a2);
            chk(map_word_out, f ? 32'hf0f0_0f0f : 32'hfe1e_01f0);
        end
        // reset in mid-run must bring the control register back to zero
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        host_u.rd(1'b1, v, o);
        chk({o, v}, 17'h00000);
        results;
    end
    initial begin
        #100000;
        n_errors++;
        results;
    end
endmodule : tb_top
